// file: src/framer_ctrl_pkg.sv
// constants, layouts and carrier types for the framer mode control block
package framer_ctrl_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam int NUM_CNT = 4;

	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFF_MODE_ONE = 8'h00;
	localparam logic [7:0] OFF_SIC_ONE = 8'h01;
	localparam logic [7:0] OFF_SIC_TWO = 8'h02;
	localparam logic [7:0] OFF_CNT_DIS = 8'h03;
	localparam logic [7:0] OFF_LOOP_CTL = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h05;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h06;
	localparam logic [7:0] OFF_IRQ_EN = 8'h07;
	// counters: framing, crc, code violation, block; low byte then high byte
	localparam logic [7:0] OFF_CNT_BASE = 8'h08;
	localparam logic [7:0] OFF_CNT_LAST = 8'h0f;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int MODE_ONE_COUNTER_MODE = 3;
	localparam int MODE_ONE_RATE_LOW = 2;
	localparam int MODE_ONE_ALARM_REMOTE = 1;
	localparam int SIC_ONE_RATE_HIGH = 1;
	localparam int SIC_TWO_RATE_FAMILY = 1;
	localparam int LOOP_CTL_LOCAL = 0;
	localparam int IRQ_SECOND = 0;
	localparam int IRQ_CNT_FULL = 1;
	localparam int IRQ_W = 2;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_MODE_ONE = 8'h00;
	localparam logic [7:0] RST_SIC_ONE = 8'h00;
	localparam logic [7:0] RST_SIC_TWO = 8'h00;
	localparam logic [3:0] RST_CNT_DIS = 4'h0;
	localparam logic [7:0] RST_LOOP_CTL = 8'h00;
	localparam logic [1:0] RST_IRQ = 2'h0;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ONE_SECOND_US = 1000000;
	localparam int ONE_SECOND_CYCLES = ONE_SECOND_US * 1000 / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// highway rates in kbit/s
	localparam logic [14:0] KBPS_2048 = 15'h0800;
	localparam logic [14:0] KBPS_4096 = 15'h1000;
	localparam logic [14:0] KBPS_8192 = 15'h2000;
	localparam logic [14:0] KBPS_16384 = 15'h4000;
	localparam logic [14:0] KBPS_1544 = 15'h0608;
	localparam logic [14:0] KBPS_3088 = 15'h0c10;
	localparam logic [14:0] KBPS_6176 = 15'h1820;
	localparam logic [14:0] KBPS_12352 = 15'h3040;

	typedef enum logic [2:0] {
		RATE_2048,
		RATE_4096,
		RATE_8192,
		RATE_16384,
		RATE_1544,
		RATE_3088,
		RATE_6176,
		RATE_12352
	} rate_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic a;
		logic b;
	} line_pair_t;

endpackage

// file: src/error_counter.sv
// one error counter with freeze-and-clear or one-second latch operation
`timescale 1ns/1ps
module error_counter #(
	parameter int WIDTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic err_i,
	input wire logic latch_mode_i,
	input wire logic disable_i,
	input wire logic second_i,
	output logic [WIDTH-1:0] value_o,
	output logic full_o
);

	typedef struct packed {
		logic [WIDTH-1:0] run;
		logic [WIDTH-1:0] held;
		logic dis_q;
		logic full;
	} cnt_state_t;

	cnt_state_t st;
	cnt_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.dis_q = disable_i;
		next_st.full = 1'b0;
		if (latch_mode_i) begin
			if (second_i) begin
				// latch the second's total, restart counting from this cycle's event
				next_st.held = st.run;
				next_st.run = {{(WIDTH-1){1'b0}}, err_i};
			end else if (err_i && st.run != {WIDTH{1'b1}}) begin
				next_st.run = st.run + 1'b1;
			end
		end else begin
			if (disable_i && !st.dis_q) begin
				// keep the total for the host to read, then restart from zero
				next_st.held = st.run;
				next_st.run = '0;
			end else if (err_i && !disable_i && st.run != {WIDTH{1'b1}}) begin
				// frozen while disabled so the host reads a stable value
				next_st.run = st.run + 1'b1;
			end
		end
		if (next_st.run == {WIDTH{1'b1}} && st.run != {WIDTH{1'b1}}) begin
			next_st.full = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign value_o = st.held;
	assign full_o = st.full;

endmodule

// file: src/framer_mode_ctrl.sv
// framer mode control: error counters, highway rate, remote alarm and local loop
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module framer_mode_ctrl #(
	parameter int unsigned SECOND_CYCLES = framer_ctrl_pkg::ONE_SECOND_CYCLES,
	parameter int CNT_W = framer_ctrl_pkg::CNT_W
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire framer_ctrl_pkg::reg_req_t req_i,
	output logic [7:0] rd_data_o,
	input wire logic [3:0] err_event_i,
	input wire framer_ctrl_pkg::line_pair_t tx_line_i,
	input wire logic sys_tx_i,
	input wire logic line_rx_i,
	output framer_ctrl_pkg::line_pair_t tx_line_o,
	output logic sys_rx_o,
	output framer_ctrl_pkg::rate_t highway_rate_o,
	output logic [14:0] highway_kbps_o,
	output logic irq_o
);

	localparam int SEC_W = $clog2(SECOND_CYCLES + 1);
	localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SECOND_CYCLES - 1);

	typedef struct packed {
		logic [7:0] mode_one;
		logic [7:0] sic_one;
		logic [7:0] sic_two;
		logic [3:0] cnt_dis;
		logic [7:0] loop_ctl;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic [SEC_W-1:0] sec_cnt;
		logic sec_tick;
		logic [7:0] rd_data;
		logic [7:0] hi_snap;
		logic irq;
		framer_ctrl_pkg::line_pair_t line_out;
		logic sys_rx;
		framer_ctrl_pkg::rate_t rate;
		logic [14:0] kbps;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;

	logic [CNT_W-1:0] cnt_val [framer_ctrl_pkg::NUM_CNT];
	logic [framer_ctrl_pkg::NUM_CNT-1:0] cnt_full;
	logic latch_mode;

	////////////////////////////////////////////////////////////////////////////
	// error counters

	assign latch_mode = st.mode_one[framer_ctrl_pkg::MODE_ONE_COUNTER_MODE];

	generate
		for (genvar i = 0; i < framer_ctrl_pkg::NUM_CNT; i++) begin : g_cnt
			error_counter #(
				.WIDTH(CNT_W)
			) u_cnt (
				.ref_clk_i(ref_clk_i),
				.nrst_i(nrst_i),
				.err_i(err_event_i[i]),
				.latch_mode_i(latch_mode),
				.disable_i(st.cnt_dis[i]),
				.second_i(st.sec_tick),
				.value_o(cnt_val[i]),
				.full_o(cnt_full[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [1:0] rate_code;
		logic [1:0] irq_set;
		logic [1:0] irq_clr;
		rate_code = 2'h0;
		irq_set = 2'h0;
		irq_clr = 2'h0;
		next_st = st;

		// one-second timebase
		if (st.sec_cnt == SEC_LAST) begin
			next_st.sec_cnt = '0;
			next_st.sec_tick = 1'b1;
		end else begin
			next_st.sec_cnt = st.sec_cnt + 1'b1;
			next_st.sec_tick = 1'b0;
		end

		// register writes
		if (req_i.wr) begin
			unique case (req_i.addr)
				framer_ctrl_pkg::OFF_MODE_ONE: begin
					next_st.mode_one = req_i.wdata;
				end
				framer_ctrl_pkg::OFF_SIC_ONE: begin
					next_st.sic_one = req_i.wdata;
				end
				framer_ctrl_pkg::OFF_SIC_TWO: begin
					next_st.sic_two = req_i.wdata;
				end
				framer_ctrl_pkg::OFF_CNT_DIS: begin
					next_st.cnt_dis = req_i.wdata[3:0];
				end
				framer_ctrl_pkg::OFF_LOOP_CTL: begin
					next_st.loop_ctl = req_i.wdata;
				end
				framer_ctrl_pkg::OFF_IRQ_STAT: begin
					// status is read-only, writes are ignored
				end
				framer_ctrl_pkg::OFF_IRQ_CLR: begin
					irq_clr = req_i.wdata[1:0];
				end
				framer_ctrl_pkg::OFF_IRQ_EN: begin
					next_st.irq_en = req_i.wdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// sticky status: a new event wins over a clear in the same cycle
		irq_set[framer_ctrl_pkg::IRQ_SECOND] = st.sec_tick;
		irq_set[framer_ctrl_pkg::IRQ_CNT_FULL] = |cnt_full;
		next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
		next_st.irq = |(next_st.irq_stat & next_st.irq_en);

		// register reads, data in the following cycle only
		next_st.rd_data = 8'h00;
		if (req_i.rd) begin
			unique case (req_i.addr)
				framer_ctrl_pkg::OFF_MODE_ONE: begin
					next_st.rd_data = st.mode_one;
				end
				framer_ctrl_pkg::OFF_SIC_ONE: begin
					next_st.rd_data = st.sic_one;
				end
				framer_ctrl_pkg::OFF_SIC_TWO: begin
					next_st.rd_data = st.sic_two;
				end
				framer_ctrl_pkg::OFF_CNT_DIS: begin
					next_st.rd_data = {4'h0, st.cnt_dis};
				end
				framer_ctrl_pkg::OFF_LOOP_CTL: begin
					next_st.rd_data = st.loop_ctl;
				end
				framer_ctrl_pkg::OFF_IRQ_STAT: begin
					next_st.rd_data = {6'h00, st.irq_stat};
				end
				framer_ctrl_pkg::OFF_IRQ_EN: begin
					next_st.rd_data = {6'h00, st.irq_en};
				end
				framer_ctrl_pkg::OFF_IRQ_CLR: begin
					// write-only, reads as zero
				end
				// a low-byte read keeps the high byte, so the pair shows one count
				framer_ctrl_pkg::OFF_CNT_BASE: begin
					// framing errors
					next_st.rd_data = cnt_val[0][7:0];
					next_st.hi_snap = cnt_val[0][15:8];
				end
				framer_ctrl_pkg::OFF_CNT_BASE + 8'h01: begin
					next_st.rd_data = st.hi_snap;
				end
				framer_ctrl_pkg::OFF_CNT_BASE + 8'h02: begin
					// crc errors
					next_st.rd_data = cnt_val[1][7:0];
					next_st.hi_snap = cnt_val[1][15:8];
				end
				framer_ctrl_pkg::OFF_CNT_BASE + 8'h03: begin
					next_st.rd_data = st.hi_snap;
				end
				framer_ctrl_pkg::OFF_CNT_BASE + 8'h04: begin
					// code violations
					next_st.rd_data = cnt_val[2][7:0];
					next_st.hi_snap = cnt_val[2][15:8];
				end
				framer_ctrl_pkg::OFF_CNT_BASE + 8'h05: begin
					next_st.rd_data = st.hi_snap;
				end
				framer_ctrl_pkg::OFF_CNT_BASE + 8'h06: begin
					// block errors
					next_st.rd_data = cnt_val[3][7:0];
					next_st.hi_snap = cnt_val[3][15:8];
				end
				framer_ctrl_pkg::OFF_CNT_BASE + 8'h07: begin
					next_st.rd_data = st.hi_snap;
				end
				default: begin
				end
			endcase
		end

		// highway rate decode
		rate_code = {st.sic_one[framer_ctrl_pkg::SIC_ONE_RATE_HIGH],
			st.mode_one[framer_ctrl_pkg::MODE_ONE_RATE_LOW]};
		if (!st.sic_two[framer_ctrl_pkg::SIC_TWO_RATE_FAMILY]) begin
			unique case (rate_code)
				2'h0: begin
					next_st.rate = framer_ctrl_pkg::RATE_2048;
					next_st.kbps = framer_ctrl_pkg::KBPS_2048;
				end
				2'h1: begin
					next_st.rate = framer_ctrl_pkg::RATE_4096;
					next_st.kbps = framer_ctrl_pkg::KBPS_4096;
				end
				2'h2: begin
					next_st.rate = framer_ctrl_pkg::RATE_8192;
					next_st.kbps = framer_ctrl_pkg::KBPS_8192;
				end
				2'h3: begin
					next_st.rate = framer_ctrl_pkg::RATE_16384;
					next_st.kbps = framer_ctrl_pkg::KBPS_16384;
				end
			endcase
		end else begin
			unique case (rate_code)
				2'h0: begin
					next_st.rate = framer_ctrl_pkg::RATE_1544;
					next_st.kbps = framer_ctrl_pkg::KBPS_1544;
				end
				2'h1: begin
					next_st.rate = framer_ctrl_pkg::RATE_3088;
					next_st.kbps = framer_ctrl_pkg::KBPS_3088;
				end
				2'h2: begin
					next_st.rate = framer_ctrl_pkg::RATE_6176;
					next_st.kbps = framer_ctrl_pkg::KBPS_6176;
				end
				2'h3: begin
					next_st.rate = framer_ctrl_pkg::RATE_12352;
					next_st.kbps = framer_ctrl_pkg::KBPS_12352;
				end
			endcase
		end

		// line side: alarm replaces both outputs with ones
		if (st.mode_one[framer_ctrl_pkg::MODE_ONE_ALARM_REMOTE]) begin
			next_st.line_out = '{a: 1'b1, b: 1'b1};
		end else begin
			next_st.line_out = tx_line_i;
		end

		// system side: local loop returns transmit data untouched
		if (st.loop_ctl[framer_ctrl_pkg::LOOP_CTL_LOCAL]) begin
			next_st.sys_rx = sys_tx_i;
		end else begin
			next_st.sys_rx = line_rx_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st.mode_one <= framer_ctrl_pkg::RST_MODE_ONE;
			st.sic_one <= framer_ctrl_pkg::RST_SIC_ONE;
			st.sic_two <= framer_ctrl_pkg::RST_SIC_TWO;
			st.cnt_dis <= framer_ctrl_pkg::RST_CNT_DIS;
			st.loop_ctl <= framer_ctrl_pkg::RST_LOOP_CTL;
			st.irq_stat <= framer_ctrl_pkg::RST_IRQ;
			st.irq_en <= framer_ctrl_pkg::RST_IRQ;
			st.sec_cnt <= '0;
			st.sec_tick <= 1'b0;
			st.rd_data <= 8'h00;
			st.hi_snap <= 8'h00;
			st.irq <= 1'b0;
			st.line_out <= '0;
			st.sys_rx <= 1'b0;
			st.rate <= framer_ctrl_pkg::RATE_2048;
			st.kbps <= framer_ctrl_pkg::KBPS_2048;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rd_data_o = st.rd_data;
	assign tx_line_o = st.line_out;
	assign sys_rx_o = st.sys_rx;
	assign highway_rate_o = st.rate;
	assign highway_kbps_o = st.kbps;
	assign irq_o = st.irq;

endmodule

// file: sim/framer_mode_chk.sv
// port assertions for the framer mode control block
`timescale 1ns/1ps
module framer_mode_chk (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire framer_ctrl_pkg::reg_req_t req_i,
	input wire logic [7:0] rd_data_o,
	input wire logic [3:0] err_event_i,
	input wire framer_ctrl_pkg::line_pair_t tx_line_i,
	input wire logic sys_tx_i,
	input wire logic line_rx_i,
	input wire framer_ctrl_pkg::line_pair_t tx_line_o,
	input wire logic sys_rx_o,
	input wire framer_ctrl_pkg::rate_t highway_rate_o,
	input wire logic [14:0] highway_kbps_o,
	input wire logic irq_o
);
	logic [7:0] sh [8];
	logic [2:0] rc;
	// shadow of the writable registers, updated on the same edge as the design
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 8; i++) begin
				sh[i] <= 8'h00;
			end
		end else if (req_i.wr && req_i.addr < 8'h08) begin
			sh[req_i.addr[2:0]] <= req_i.wdata;
		end
	end
	assign rc = {sh[2][1], sh[1][1], sh[0][2]};
	// an enable write in this cycle may raise the interrupt at the next edge
	logic en_wr;
	assign en_wr = req_i.wr && req_i.addr == framer_ctrl_pkg::OFF_IRQ_EN;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_rd_mode;
		req_i.rd && req_i.addr == framer_ctrl_pkg::OFF_MODE_ONE;
	endsequence
	sequence s_rd_hole;
		req_i.rd && (req_i.addr > framer_ctrl_pkg::OFF_CNT_LAST || req_i.addr == framer_ctrl_pkg::OFF_IRQ_CLR);
	endsequence
	a_alarm_all_ones: assert property (sh[0][1] |=> tx_line_o == 2'b11)
		else $error("alarm pattern missing on line outputs");
	a_line_pass_through: assert property (!sh[0][1] |=> tx_line_o == $past(tx_line_i))
		else $error("line outputs do not follow transmit data");
	a_loop_returns_tx: assert property (sh[4][0] |=> sys_rx_o == $past(sys_tx_i))
		else $error("local loop data altered");
	a_no_loop_rx: assert property (!sh[4][0] |=> sys_rx_o == $past(line_rx_i))
		else $error("receive data wrong without loop");
	a_rate_select: assert property (highway_rate_o == $past(rc))
		else $error("highway rate does not match selects");
	a_read_idle_zero: assert property (!req_i.rd |=> rd_data_o == 8'h00)
		else $error("read data not zero outside a read");
	a_hole_reads_zero: assert property (s_rd_hole |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	a_mode_read_back: assert property (s_rd_mode |=> rd_data_o == $past(sh[0]))
		else $error("mode register read back wrong");
	a_irq_masked_low: assert property (sh[7][1:0] == 2'h0 && !en_wr |=> !irq_o)
		else $error("interrupt high while masked");
endmodule
bind framer_mode_ctrl framer_mode_chk u_chk (
	.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req_i), .rd_data_o(rd_data_o),
	.err_event_i(err_event_i), .tx_line_i(tx_line_i), .sys_tx_i(sys_tx_i), .line_rx_i(line_rx_i),
	.tx_line_o(tx_line_o), .sys_rx_o(sys_rx_o), .highway_rate_o(highway_rate_o),
	.highway_kbps_o(highway_kbps_o), .irq_o(irq_o)
);

// file: sim/line_far_end.sv
// remote line end model: data patterns and line error pulses
`timescale 1ns/1ps
module line_far_end (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic err_on_i,
	output logic [3:0] err_event_o,
	output framer_ctrl_pkg::line_pair_t tx_line_o,
	output logic sys_tx_o,
	output logic line_rx_o
);
	logic [3:0] pat;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pat <= 4'h0;
		end else begin
			pat <= pat + 4'h1;
		end
	end
	// data changes every cycle so a value one cycle stale never matches
	assign tx_line_o = pat[1:0];
	assign sys_tx_o = pat[0];
	assign line_rx_o = ~pat[0];
	assign err_event_o = {4{err_on_i & pat[0]}};
endmodule

// file: sim/testbench.sv
// self-checking testbench for the framer mode control block
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic err_on = 1'b0;
	framer_ctrl_pkg::reg_req_t req = '0;
	framer_ctrl_pkg::line_pair_t txl_in, txl_out;
	framer_ctrl_pkg::rate_t rate;
	logic [7:0] rd_data;
	logic [3:0] err_ev;
	logic sys_tx, line_rx, sys_rx, irq;
	logic [14:0] kbps;
	int err_total = 0;
	int n_compared = 0;
	int n_err = 0;
	always #5 clk = ~clk;
	always @(posedge clk) if (err_ev[0] === 1'b1) n_err <= n_err + 1;
	line_far_end far (.ref_clk_i(clk), .nrst_i(nrst), .err_on_i(err_on), .err_event_o(err_ev),
		.tx_line_o(txl_in), .sys_tx_o(sys_tx), .line_rx_o(line_rx));
	framer_mode_ctrl #(.SECOND_CYCLES(400)) dut (.ref_clk_i(clk), .nrst_i(nrst), .req_i(req),
		.rd_data_o(rd_data), .err_event_i(err_ev), .tx_line_i(txl_in), .sys_tx_i(sys_tx),
		.line_rx_i(line_rx), .tx_line_o(txl_out), .sys_rx_o(sys_rx), .highway_rate_o(rate),
		.highway_kbps_o(kbps), .irq_o(irq));
	////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk("register", {8'h00, e}, {8'h00, d});
	endtask
	// low byte first, then high byte
	task automatic cnt(input int k, input int e);
		logic [7:0] lo, hi;
		rd(framer_ctrl_pkg::OFF_CNT_BASE + 8'(2 * k), lo);
		rd(framer_ctrl_pkg::OFF_CNT_BASE + 8'(2 * k + 1), hi);
		chk("counter", 16'(e), {hi, lo});
	endtask
	task automatic burst();
		@(posedge clk);
		err_on <= 1'b1;
		repeat (10) @(posedge clk);
		err_on <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// waits for the tick, then keeps off the counters for 1 us
	task automatic wait_irq();
		repeat (1000) begin
			@(posedge clk);
			#1;
			if (irq === 1'b1) break;
		end
		chk("irq raised", 16'h1, {15'h0, irq});
		repeat (100) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int a = 0; a < 8; a++) rchk(8'(a), 8'h00);
		rchk(8'h40, 8'h00);
		chk("reset kbps", 16'h0800, {1'b0, kbps});
	endtask
	task automatic t_rates();
		logic [14:0] kb [8] = '{framer_ctrl_pkg::KBPS_2048, framer_ctrl_pkg::KBPS_4096,
			framer_ctrl_pkg::KBPS_8192, framer_ctrl_pkg::KBPS_16384, framer_ctrl_pkg::KBPS_1544,
			framer_ctrl_pkg::KBPS_3088, framer_ctrl_pkg::KBPS_6176, framer_ctrl_pkg::KBPS_12352};
		for (int c = 0; c < 8; c++) begin
			wr(framer_ctrl_pkg::OFF_SIC_TWO, {6'h00, c[2], 1'b0});
			wr(framer_ctrl_pkg::OFF_SIC_ONE, {6'h00, c[1], 1'b0});
			wr(framer_ctrl_pkg::OFF_MODE_ONE, {5'h00, c[0], 2'b00});
			repeat (2) @(posedge clk);
			#1 chk("rate", 16'(c), {13'h0, rate});
			chk("kbps", {1'b0, kb[c]}, {1'b0, kbps});
		end
	endtask
	task automatic t_line();
		wr(framer_ctrl_pkg::OFF_MODE_ONE, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk("alarm", 16'h3, {14'h0, txl_out});
		wr(framer_ctrl_pkg::OFF_MODE_ONE, 8'h00);
		#1 chk("no loop", {15'h0, sys_tx}, {15'h0, sys_rx});
		wr(framer_ctrl_pkg::OFF_LOOP_CTL, 8'h01);
		@(posedge clk);
		#1 chk("loop", {15'h0, ~sys_tx}, {15'h0, sys_rx});
		wr(framer_ctrl_pkg::OFF_LOOP_CTL, 8'h00);
	endtask
	task automatic t_freeze();
		int n0;
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h0f);
		burst();
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h00);
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h0f);
		cnt(0, 0);
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h00);
		n0 = n_err;
		burst();
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h0f);
		for (int k = 0; k < 4; k++) cnt(k, n_err - n0);
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h0e);
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h0f);
		cnt(0, 0);
		cnt(1, n_err - n0);
	endtask
	task automatic t_latch();
		int n0;
		wr(framer_ctrl_pkg::OFF_CNT_DIS, 8'h00);
		wr(framer_ctrl_pkg::OFF_IRQ_EN, 8'h01);
		wr(framer_ctrl_pkg::OFF_IRQ_CLR, 8'h03);
		wr(framer_ctrl_pkg::OFF_MODE_ONE, 8'h08);
		wait_irq();
		wr(framer_ctrl_pkg::OFF_IRQ_CLR, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", 16'h0, {15'h0, irq});
		n0 = n_err;
		burst();
		wait_irq();
		for (int k = 0; k < 4; k++) cnt(k, n_err - n0);
		rchk(framer_ctrl_pkg::OFF_IRQ_STAT, 8'h01);
		rchk(framer_ctrl_pkg::OFF_IRQ_CLR, 8'h00);
		wr(framer_ctrl_pkg::OFF_IRQ_CLR, 8'h01);
		wait_irq();
		cnt(0, 0);
		wr(framer_ctrl_pkg::OFF_IRQ_EN, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("irq masked", 16'h0, {15'h0, irq});
		rchk(framer_ctrl_pkg::OFF_IRQ_STAT, 8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_rates();
		t_line();
		t_freeze();
		t_latch();
		conclude();
	end
	initial begin
		#200000;
		err_total++;
		conclude();
	end
endmodule
